// ---- ceac_top.sv ----
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ceac_defs.svh"

module ceac_top (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic [`CEAC_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  logic [31:0]             reg_rdata,
   input  wire logic                    module_fast_trig,
   input  wire logic                    chan_validation_trig,
   input  wire logic                    local_fast_trig,
   input  wire logic                    trace_capture_en,
   input  wire logic                    evt_valid,
   input  wire ceac_pkg::ceac_evt_t     evt,
   output var  logic                    chan_fast_trig,
   output var  logic                    input_relay_close,
   output var  logic                    run_active,
   output var  logic                    rec_valid,
   output var  ceac_pkg::ceac_dec_t     rec
);

   logic [31:0]                ctrl_a_q;
   logic [`CEAC_ENERGY_W-1:0]  ecut_q;
   logic [`CEAC_ENERGY_W-1:0]  ecut_run_q;
   logic                       run_q;
   logic                       run_start;
   ceac_pkg::ceac_cfg_t        cfg_q;
   ceac_pkg::ceac_cfg_t        cfg_d;
   logic                       overlap;
   logic                       coinc_q;
   logic                       coinc_now;
   ceac_pkg::ceac_dec_t        dec_d;
   logic [`CEAC_CNT_W-1:0]     acc_cnt_q;
   logic [`CEAC_CNT_W-1:0]     rej_cnt_q;

   // Verdict for one event under the settings of the current run
   function automatic ceac_pkg::ceac_dec_t ceac_decide(
      input ceac_pkg::ceac_cfg_t       cfg,
      input ceac_pkg::ceac_evt_t       e,
      input logic                      coinc,
      input logic                      trace_en,
      input logic [`CEAC_ENERGY_W-1:0] thr
   );
      ceac_pkg::ceac_dec_t d;
      logic                pass_mode;
      logic                hdr_only;
      logic                too_big;
      pass_mode = 1'b0;
      hdr_only  = 1'b0;
      case (cfg.pileup_mode)
         ceac_pkg::ceac_pu_all: begin
            pass_mode = 1'b1;
         end
         ceac_pkg::ceac_pu_single_only: begin
            pass_mode = !e.piled_up;
         end
         ceac_pkg::ceac_pu_single_hdr: begin
            pass_mode = 1'b1;
            hdr_only  = !e.piled_up;
         end
         ceac_pkg::ceac_pu_piled_only: begin
            pass_mode = e.piled_up;
         end
         default: begin
            pass_mode = 1'b0;
         end
      endcase
      // Piled-up events carry no energy, so the cut only sees single ones
      too_big = cfg.large_pulse_trace_suppress && !e.piled_up
                && (e.energy > thr);
      d.record         = pass_mode && (coinc || !cfg.chan_validation_required);
      d.keep_trace     = d.record && trace_en && !hdr_only && !too_big;
      d.compute_energy = d.record && !e.piled_up;
      return d;
   endfunction

   // Register writes; the run bit is the only one that acts at once
   assign run_start = reg_wr && (reg_addr == `CEAC_OFF_RUN)
                      && reg_wdata[`CEAC_B_RUN] && !run_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_a_q <= `CEAC_CTRL_A_RST;
         ecut_q   <= `CEAC_ECUT_RST;
         run_q    <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `CEAC_OFF_CTRL_A: begin
               ctrl_a_q <= reg_wdata;
            end
            `CEAC_OFF_ECUT: begin
               ecut_q <= reg_wdata[`CEAC_ENERGY_W-1:0];
            end
            `CEAC_OFF_RUN: begin
               run_q <= reg_wdata[`CEAC_B_RUN];
            end
            default: begin
               run_q <= run_q;
            end
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= `CEAC_RDATA_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            `CEAC_OFF_CTRL_A: reg_rdata <= ctrl_a_q;
            `CEAC_OFF_ECUT:   reg_rdata <= {{(32-`CEAC_ENERGY_W){1'b0}}, ecut_q};
            `CEAC_OFF_RUN:    reg_rdata <= {31'h0000_0000, run_q};
            `CEAC_OFF_STAT:   reg_rdata <= {rej_cnt_q, acc_cnt_q};
            default:          reg_rdata <= `CEAC_RDATA_ZERO;
         endcase
      end else begin
         reg_rdata <= `CEAC_RDATA_ZERO;
      end
   end

   // Settings seen by the logic; software edits mid-run cannot tear an event
   always_comb begin
      cfg_d.chan_validation_required   = ctrl_a_q[`CEAC_B_CHAN_VAL];
      cfg_d.input_relay_close          = ctrl_a_q[`CEAC_B_RELAY];
      cfg_d.pileup_mode                = ceac_pkg::ceac_pu_mode_t'(
                                         ctrl_a_q[`CEAC_F_PILE_HI:`CEAC_F_PILE_LO]);
      cfg_d.large_pulse_trace_suppress = ctrl_a_q[`CEAC_B_TRACE_CUT];
      cfg_d.group_trigger_select       = ctrl_a_q[`CEAC_B_GROUP_SEL];
      cfg_d.fast_trigger_select        = ctrl_a_q[`CEAC_B_FAST_SEL];
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_q      <= '0;
         ecut_run_q <= `CEAC_ECUT_RST;
      end else if (run_start) begin
         cfg_q      <= cfg_d;
         ecut_run_q <= ecut_q;
      end
   end

   assign run_active        = run_q;
   assign input_relay_close = cfg_q.input_relay_close;

   // Fast trigger source selection
   ceac_trig_sel u_trig_sel (
      .sys_clk              (sys_clk),
      .reset                (reset),
      .fast_trigger_select  (cfg_q.fast_trigger_select),
      .group_trigger_select (cfg_q.group_trigger_select),
      .module_fast_trig     (module_fast_trig),
      .chan_validation_trig (chan_validation_trig),
      .local_fast_trig      (local_fast_trig),
      .chan_fast_trig       (chan_fast_trig)
   );

   // Coincidence since last event; a fresh overlap beats the clear
   assign overlap   = chan_fast_trig && chan_validation_trig;
   assign coinc_now = coinc_q || overlap;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         coinc_q <= 1'b0;
      end else if (overlap) begin
         coinc_q <= 1'b1;
      end else if (evt_valid) begin
         coinc_q <= 1'b0;
      end
   end

   assign dec_d = ceac_decide(cfg_q, evt, coinc_now, trace_capture_en, ecut_run_q);

   // Verdict stands for one cycle, one cycle after the event strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rec_valid <= 1'b0;
         rec       <= '0;
      end else begin
         rec_valid <= evt_valid && run_q;
         rec       <= (evt_valid && run_q) ? dec_d : '0;
      end
   end

   // Accepted and discarded event counts, cleared at each run start
   always_ff @(posedge sys_clk) begin
      if (reset || run_start) begin
         acc_cnt_q <= `CEAC_CNT_RST;
         rej_cnt_q <= `CEAC_CNT_RST;
      end else if (evt_valid && run_q) begin
         if (dec_d.record) begin
            acc_cnt_q <= acc_cnt_q + `CEAC_CNT_ONE;
         end else begin
            rej_cnt_q <= rej_cnt_q + `CEAC_CNT_ONE;
         end
      end
   end

   // Checks on the verdict, the relay, the trigger path and the held settings
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic evt_in_run;
   assign evt_in_run = evt_valid && run_q;

   property p_chan_val;
      evt_in_run && cfg_q.chan_validation_required && !coinc_now |=> rec_valid && !rec.record;
   endproperty
   a_chan_val: assert property (p_chan_val) else $error("Event kept without coincidence");

   property p_relay;
      run_start |=> input_relay_close == $past(ctrl_a_q[`CEAC_B_RELAY]);
   endproperty
   a_relay: assert property (p_relay) else $error("Relay not following control bit");

   property p_mode_all;
      evt_in_run && cfg_q.pileup_mode == ceac_pkg::ceac_pu_all
      && (coinc_now || !cfg_q.chan_validation_required)
      |=> rec_valid && rec.record;
   endproperty
   a_mode_all: assert property (p_mode_all) else $error("Mode 00 dropped an event");


   property p_mode_single;
      evt_in_run && cfg_q.pileup_mode == ceac_pkg::ceac_pu_single_only && evt.piled_up
      |=> !rec.record;
   endproperty
   a_mode_single: assert property (p_mode_single) else $error("Mode 01 kept pileup");

   property p_mode_hdr;
      evt_in_run && cfg_q.pileup_mode == ceac_pkg::ceac_pu_single_hdr
      |=> rec.keep_trace == ($past(evt.piled_up) && $past(trace_capture_en)
          && rec.record);
   endproperty
   a_mode_hdr: assert property (p_mode_hdr) else $error("Mode 10 trace wrong");

   property p_mode_piled;
      evt_in_run && cfg_q.pileup_mode == ceac_pkg::ceac_pu_piled_only && !evt.piled_up
      |=> !rec.record;
   endproperty
   a_mode_piled: assert property (p_mode_piled) else $error("Mode 11 kept single");

   property p_no_energy;
      evt_in_run && evt.piled_up |=> rec_valid && !rec.compute_energy;
   endproperty
   a_no_energy: assert property (p_no_energy) else $error("Energy on piled event");

   property p_trace_cut;
      evt_in_run && cfg_q.large_pulse_trace_suppress && (evt.energy > ecut_run_q)
      |=> !rec.keep_trace;
   endproperty
   a_trace_cut: assert property (p_trace_cut) else $error("Large pulse kept trace");

   property p_fast_sel;
      cfg_q.fast_trigger_select && !run_start |=> chan_fast_trig == $past(module_fast_trig);
   endproperty
   a_fast_sel: assert property (p_fast_sel) else $error("Module trigger not used");

   property p_group_sel;
      !cfg_q.fast_trigger_select && cfg_q.group_trigger_select && !run_start
      |=> chan_fast_trig == $past(chan_validation_trig);
   endproperty
   a_group_sel: assert property (p_group_sel) else $error("Group trigger not used");

   property p_local_sel;
      !cfg_q.fast_trigger_select && !cfg_q.group_trigger_select && !run_start
      |=> chan_fast_trig == $past(local_fast_trig);
   endproperty
   a_local_sel: assert property (p_local_sel) else $error("Local trigger not used");

   property p_hold;
      !run_start |=> $stable(cfg_q) && $stable(ecut_run_q);
   endproperty
   a_hold: assert property (p_hold) else $error("Settings moved outside run start");

   c_hdr_only: cover property (evt_in_run && cfg_q.pileup_mode == ceac_pkg::ceac_pu_single_hdr
                               && !evt.piled_up ##1 rec.record && !rec.keep_trace);
   c_coinc_reject: cover property (evt_in_run && cfg_q.chan_validation_required && !coinc_now);
   c_trace_cut: cover property (evt_in_run && cfg_q.large_pulse_trace_suppress
                                && evt.energy > ecut_run_q && trace_capture_en);

endmodule

`default_nettype wire

// ---- ceac_defs.svh ----
`ifndef CEAC_DEFS_SVH
`define CEAC_DEFS_SVH

// Register offsets on the plain register port
`define CEAC_ADDR_W        4
`define CEAC_OFF_CTRL_A    4'h0
`define CEAC_OFF_ECUT      4'h4
`define CEAC_OFF_RUN       4'h8
`define CEAC_OFF_STAT      4'hc

// Field positions inside channel_control_a
`define CEAC_B_FAST_SEL    0
`define CEAC_B_CHAN_VAL    13
`define CEAC_B_RELAY       14
`define CEAC_F_PILE_LO     15
`define CEAC_F_PILE_HI     16
`define CEAC_B_TRACE_CUT   17
`define CEAC_B_GROUP_SEL   18

// Field positions in the run and status registers
`define CEAC_B_RUN         0
`define CEAC_F_ACC_LO      0
`define CEAC_F_ACC_HI      15
`define CEAC_F_REJ_LO      16
`define CEAC_F_REJ_HI      31

// Widths and reset values
`define CEAC_ENERGY_W      16
`define CEAC_CNT_W         16
`define CEAC_CTRL_A_RST    32'h0000_0000
`define CEAC_ECUT_RST      16'h0000
`define CEAC_CNT_RST       16'h0000
`define CEAC_CNT_ONE       16'h0001
`define CEAC_RDATA_ZERO    32'h0000_0000

`endif

// ---- ceac_pkg.sv ----
`default_nettype none
`include "ceac_defs.svh"

package ceac_pkg;

   // Pileup acceptance modes, field [16:15] of channel_control_a
   typedef enum logic [1:0] {
      ceac_pu_all         = 2'b00,
      ceac_pu_single_only = 2'b01,
      ceac_pu_single_hdr  = 2'b10,
      ceac_pu_piled_only  = 2'b11
   } ceac_pu_mode_t;

   // Event offered by the trigger and pileup logic
   typedef struct packed {
      logic                       piled_up;
      logic [`CEAC_ENERGY_W-1:0]  energy;
   } ceac_evt_t;

   // Verdict handed to the list mode recorder
   typedef struct packed {
      logic record;
      logic keep_trace;
      logic compute_energy;
   } ceac_dec_t;

   // Run-time copy of the control bits this block uses
   typedef struct packed {
      logic          chan_validation_required;
      logic          input_relay_close;
      ceac_pu_mode_t pileup_mode;
      logic          large_pulse_trace_suppress;
      logic          group_trigger_select;
      logic          fast_trigger_select;
   } ceac_cfg_t;

endpackage

`default_nettype wire

// ---- ceac_trig_sel.sv ----
`timescale 1ns/1ps
`default_nettype none

// Fast trigger source multiplexer, registered to keep the output glitch free
module ceac_trig_sel (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic fast_trigger_select,
   input  wire logic group_trigger_select,
   input  wire logic module_fast_trig,
   input  wire logic chan_validation_trig,
   input  wire logic local_fast_trig,
   output var  logic chan_fast_trig
);

   logic sel_d;

   // Module trigger overrides group select; group picks validation over local
   always_comb begin
      if (fast_trigger_select) begin
         sel_d = module_fast_trig;
      end else if (group_trigger_select) begin
         sel_d = chan_validation_trig;
      end else begin
         sel_d = local_fast_trig;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         chan_fast_trig <= 1'b0;
      end else begin
         chan_fast_trig <= sel_d;
      end
   end

endmodule

`default_nettype wire

// ---- ceac_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ceac_defs.svh"

// Directed bench for the channel event acceptance block
module ceac_top_tb;
   logic                    sys_clk;
   logic                    reset;
   logic [`CEAC_ADDR_W-1:0] reg_addr;
   logic [31:0]             reg_wdata;
   logic                    reg_wr;
   logic                    reg_rd;
   logic [31:0]             reg_rdata;
   logic                    module_fast_trig;
   logic                    chan_validation_trig;
   logic                    local_fast_trig;
   logic                    trace_capture_en;
   logic                    evt_valid;
   ceac_pkg::ceac_evt_t     evt;
   logic                    chan_fast_trig;
   logic                    input_relay_close;
   logic                    run_active;
   logic                    rec_valid;
   ceac_pkg::ceac_dec_t     rec;
   int                      fails;
   int                      check_count;

   ceac_top ceac_top_inst (
      .sys_clk              (sys_clk),
      .reset                (reset),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .module_fast_trig     (module_fast_trig),
      .chan_validation_trig (chan_validation_trig),
      .local_fast_trig      (local_fast_trig),
      .trace_capture_en     (trace_capture_en),
      .evt_valid            (evt_valid),
      .evt                  (evt),
      .chan_fast_trig       (chan_fast_trig),
      .input_relay_close    (input_relay_close),
      .run_active           (run_active),
      .rec_valid            (rec_valid),
      .rec                  (rec)
   );

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Comparisons, one per kind of result
   task automatic cmp32(input logic [31:0] exp, input logic [31:0] act);
      check_count++;
      if (act !== exp) begin
         fails++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, act);
      end
   endtask

   task automatic cmp3(input logic [2:0] exp, input logic [2:0] act);
      check_count++;
      if (act !== exp) begin
         fails++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, act);
      end
   endtask

   task automatic cmp1(input logic exp, input logic act);
      check_count++;
      if (act !== exp) begin
         fails++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, act);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Bus cycles; every task is entered and left just after a rising edge
   // An idle edge after each write keeps the strobe from being set twice in one step
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Read data is sampled mid-cycle, clear of the edge where it changes
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
      @(posedge sys_clk);
   endtask

   // Settings only reach the working set on a fresh run start
   task automatic start_run(input logic [31:0] ctrl, input logic [15:0] thr);
      reg_write(`CEAC_OFF_CTRL_A, ctrl);
      reg_write(`CEAC_OFF_ECUT, {16'h0000, thr});
      reg_write(`CEAC_OFF_RUN, 32'h0000_0000);
      reg_write(`CEAC_OFF_RUN, 32'h0000_0001);
      @(posedge sys_clk);
   endtask

   task automatic send_evt(input logic p, input logic [15:0] e,
                           output logic v, output logic [2:0] r);
      evt_valid <= 1'b1;
      evt       <= {p, e};
      @(posedge sys_clk);
      evt_valid <= 1'b0;
      @(negedge sys_clk);
      v = rec_valid;
      r = rec;
      @(posedge sys_clk);
   endtask

   // Reset values, read-back, unmapped and read-only places, refused events
   task automatic t_regs;
      logic [31:0] d;
      logic        v;
      logic [2:0]  r;
      cmp1(1'b0, input_relay_close);
      cmp1(1'b0, run_active);
      for (int a = 0; a < 16; a += 2) begin
         reg_read(a[3:0], d);
         cmp32(32'h0000_0000, d);
      end
      reg_write(`CEAC_OFF_CTRL_A, 32'ha5a5_5a5a);
      reg_read(`CEAC_OFF_CTRL_A, d);
      cmp32(32'ha5a5_5a5a, d);
      @(negedge sys_clk);
      cmp32(32'h0000_0000, reg_rdata);
      @(posedge sys_clk);
      reg_write(`CEAC_OFF_STAT, 32'hffff_ffff);
      reg_write(`CEAC_OFF_CTRL_A, 32'h0000_0000);
      reg_read(`CEAC_OFF_STAT, d);
      cmp32(32'h0000_0000, d);
      send_evt(1'b0, 16'h0001, v, r);
      cmp1(1'b0, v);
   endtask

   // All four pileup modes against single and piled-up events, with counts
   task automatic t_pileup;
      logic [31:0] d;
      logic        v;
      logic [2:0]  r;
      logic        rcd;
      int          acc;
      trace_capture_en <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         start_run({15'h0000, m[1:0], 15'h0000}, 16'hffff);
         acc = 0;
         for (int p = 0; p < 2; p++) begin
            send_evt(p[0], 16'h0010, v, r);
            rcd = (m == 1) ? !p[0] : (m == 3) ? p[0] : 1'b1;
            acc += rcd;
            cmp1(1'b1, v);
            cmp3({rcd, rcd & !(m == 2 && !p[0]), rcd & !p[0]}, r);
         end
         reg_read(`CEAC_OFF_STAT, d);
         cmp32({16'(2 - acc), 16'(acc)}, d);
      end
   endtask

   // Trace cut at the threshold boundary, held through an in-run rewrite
   task automatic t_cut;
      logic       v;
      logic [2:0] r;
      start_run(32'h0002_0000, 16'h0100);
      send_evt(1'b0, 16'h0100, v, r);
      cmp3(3'h7, r);
      send_evt(1'b0, 16'h0101, v, r);
      cmp3(3'h5, r);
      reg_write(`CEAC_OFF_CTRL_A, 32'h0000_0000);
      send_evt(1'b0, 16'h0101, v, r);
      cmp3(3'h5, r);
      trace_capture_en <= 1'b0;
      send_evt(1'b0, 16'h0010, v, r);
      cmp3(3'h5, r);
      trace_capture_en <= 1'b1;
      start_run(32'h0000_0000, 16'h0100);
      send_evt(1'b0, 16'hffff, v, r);
      cmp3(3'h7, r);
   endtask

   // Relay follows the run copy, not the raw register
   task automatic t_relay;
      reg_write(`CEAC_OFF_CTRL_A, 32'h0000_4000);
      @(negedge sys_clk);
      cmp1(1'b0, input_relay_close);
      @(posedge sys_clk);
      start_run(32'h0000_4000, 16'h0000);
      @(negedge sys_clk);
      cmp1(1'b1, input_relay_close);
      cmp1(1'b1, run_active);
      @(posedge sys_clk);
      start_run(32'h0000_0000, 16'h0000);
      @(negedge sys_clk);
      cmp1(1'b0, input_relay_close);
      @(posedge sys_clk);
   endtask

   // Validation alone must not count as an overlap with the fast trigger
   task automatic t_chanval;
      logic       v;
      logic [2:0] r;
      start_run(32'h0000_2000, 16'hffff);
      send_evt(1'b0, 16'h0010, v, r);
      send_evt(1'b0, 16'h0010, v, r);
      cmp3(3'h0, r);
      chan_validation_trig <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chan_validation_trig <= 1'b0;
      send_evt(1'b0, 16'h0010, v, r);
      cmp3(3'h0, r);
      chan_validation_trig <= 1'b1;
      local_fast_trig      <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chan_validation_trig <= 1'b0;
      local_fast_trig      <= 1'b0;
      send_evt(1'b0, 16'h0010, v, r);
      cmp3(3'h7, r);
   endtask

   // Every select combination against each source raised alone
   task automatic t_trig;
      logic exp;
      for (int f = 0; f < 4; f++) begin
         start_run({13'h0000, f[1], 17'h0_0000, f[0]}, 16'h0000);
         for (int s = 0; s < 3; s++) begin
            module_fast_trig     <= (s == 0);
            chan_validation_trig <= (s == 1);
            local_fast_trig      <= (s == 2);
            @(posedge sys_clk);
            @(negedge sys_clk);
            exp = f[0] ? (s == 0) : f[1] ? (s == 1) : (s == 2);
            cmp1(exp, chan_fast_trig);
            @(posedge sys_clk);
         end
      end
      module_fast_trig     <= 1'b0;
      chan_validation_trig <= 1'b0;
      local_fast_trig      <= 1'b0;
   endtask

   // Main sequence
   initial begin
      fails = 0;
      check_count = 0;
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      module_fast_trig = 1'b0;
      chan_validation_trig = 1'b0;
      local_fast_trig = 1'b0;
      trace_capture_en = 1'b0;
      evt_valid = 1'b0;
      evt = 17'h0_0000;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_pileup();
      t_cut();
      t_relay();
      t_chanval();
      t_trig();
      final_report();
   end

   // Guard against a hung run
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      final_report();
   end
endmodule

`default_nettype wire
